// File: gcdr_pkg.sv
package gcdr_pkg;

  // register byte offsets, one aligned 32-bit word each
  localparam logic [4:0] OFF_CONFIG     = 5'h00;
  localparam logic [4:0] OFF_STATUS     = 5'h04;
  localparam logic [4:0] OFF_INT_STATUS = 5'h08;
  localparam logic [4:0] OFF_INT_CLEAR  = 5'h0c;
  localparam logic [4:0] OFF_INT_ENABLE = 5'h10;
  localparam logic [4:0] OFF_TARGET     = 5'h14;
  localparam logic [4:0] OFF_HOLD       = 5'h18;

  // configuration field sits in bits 16 down to 7 of the config word
  localparam int CFG_LSB = 7;
  localparam int CFG_MSB = 16;
  localparam int CFG_W   = 10;

  // interrupt status bit positions
  localparam int INT_STALL = 0;
  localparam int INT_LOST  = 1;
  localparam int INT_HALT  = 2;
  localparam int INT_W     = 3;

  // direct coil current fields of the target position word
  localparam int COIL_W     = 9;
  localparam int COIL_A_LSB = 0;
  localparam int COIL_B_LSB = 16;
  localparam int HOLD_W     = 5;
  localparam int HOLD_SHIFT = 5;
  localparam int PROD_W     = 15;

  // hysteresis divisors for step frequency comparison
  localparam logic [5:0] HYST_DIV_LARGE = 6'h10;
  localparam logic [5:0] HYST_DIV_SMALL = 6'h20;

  // values after reset
  localparam logic [CFG_W-1:0]  CFG_RESET    = 10'h000;
  localparam logic [INT_W-1:0]  INT_RESET    = 3'h0;
  localparam logic [31:0]       TARGET_RESET = 32'h0000_0000;
  localparam logic [HOLD_W-1:0] HOLD_RESET   = 5'h00;

  typedef struct packed {
    logic direct_mode;
    logic stop_enable;
    logic small_hyst;
    logic pin_b_drive_style;
    logic pin_a_drive_style;
    logic pin_b_toggle_on_lost_step;
    logic pin_b_on_chopper_on;
    logic pin_b_on_table_zero;
    logic pin_b_opt8;
    logic pin_a_opt7;
  } gcdr_cfg_t;

  typedef struct packed {
    logic out;
    logic oe;
  } gcdr_pad_t;

  typedef enum logic {
    GCDR_BUS_IDLE   = 1'b0,
    GCDR_BUS_ANSWER = 1'b1
  } gcdr_bus_state_t;

endpackage

// File: gcdr_pin_drv.sv
`timescale 1ns/10ps
`default_nettype none

module gcdr_pin_drv #(
  parameter logic RESET_DRIVE_LOW = 1'b0
) (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        active_i,
  input  wire logic        push_pull_i,
  output gcdr_pkg::gcdr_pad_t pad_o
);

  gcdr_pkg::gcdr_pad_t pad_reg;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pad_reg.out <= 1'b0;
      pad_reg.oe  <= RESET_DRIVE_LOW;
    end else if (push_pull_i) begin
      pad_reg.out <= active_i;
      pad_reg.oe  <= 1'b1;
    end else begin
      // open collector: only ever pulls low
      pad_reg.out <= 1'b0;
      pad_reg.oe  <= active_i;
    end
  end

  assign pad_o = pad_reg;

endmodule

`default_nettype wire

// File: gcdr_top.sv
// Notes on behaviour
// - external steps and bit 7 set: pin A active on motor stall.
// - internal sequencer: bit 7 clear pin A interrupt, set half-rate step.
// - external steps and bit 8 set: pin B active on motor stall.
// - internal sequencer: bit 8 clear pin B position compare, set direction.
// - external steps and bit 9 set: pin B active at table position zero.
// - external steps and bit 10 set: pin B active while chopper on.
// - external steps and bit 11 set: pin B toggles per lost step.
// - bit 12 clear pin A open collector low, set push-pull high.
// - bit 13 clear pin B open collector low, set push-pull high.
// - bit 14 picks hysteresis one sixteenth clear, one thirty-second set.
// - bit 15 set and halt input high stops the sequencer.
// - bit 16 set: coil currents come from target position word fields.
// - step source input 1 means external steps, 0 internal sequencer.
// - pin A is driven low while the device is held in reset.
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/10ps
`default_nettype none

module gcdr_top (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             irq_o,
  // pins
  input  wire logic        step_source_select_i,
  input  wire logic        emergency_halt_input_i,
  output gcdr_pkg::gcdr_pad_t diagnostic_pin_a_pad_o,
  output gcdr_pkg::gcdr_pad_t diagnostic_pin_b_pad_o,
  // signals from the core, same clock
  input  wire logic        stall_i,
  input  wire logic        core_irq_i,
  input  wire logic        seq_step_i,
  input  wire logic        seq_dir_i,
  input  wire logic        pos_compare_i,
  input  wire logic [9:0]  mstep_pos_i,
  input  wire logic        chopper_on_i,
  input  wire logic        lost_step_inc_i,
  input  wire logic        low_velocity_i,
  // outputs to the core
  output logic             sequencer_halt_o,
  output logic [5:0]       hysteresis_divisor_o,
  output logic             direct_mode_o,
  output logic [8:0]       coil_a_current_o,
  output logic [8:0]       coil_b_current_o,
  output logic             velocity_current_reg_en_o,
  output logic             auto_current_reg_en_o
);

  function automatic logic [31:0] be_merge(
    input logic [31:0] old_value,
    input logic [31:0] new_value,
    input logic [3:0]  be
  );
    logic [31:0] merged;
    merged = old_value;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merged[i*8 +: 8] = new_value[i*8 +: 8];
      end
    end
    return merged;
  endfunction

  gcdr_pkg::gcdr_bus_state_t           bus_state_reg;
  gcdr_pkg::gcdr_cfg_t                 cfg_reg;
  logic [gcdr_pkg::INT_W-1:0]          int_status_reg;
  logic [gcdr_pkg::INT_W-1:0]          int_status_next;
  logic [gcdr_pkg::INT_W-1:0]          int_enable_reg;
  logic [gcdr_pkg::INT_W-1:0]          int_events;
  logic [gcdr_pkg::INT_W-1:0]          int_clear;
  logic [31:0]                         target_reg;
  logic [gcdr_pkg::HOLD_W-1:0]         hold_current_reg;
  logic [31:0]                         readdata_reg;
  logic [31:0]                         read_mux;
  logic [31:0]                         cfg_word;
  logic [1:0]                          meta_reg;
  logic [1:0]                          sync_reg;
  logic                                ext_steps;
  logic                                halt_active;
  logic                                halt_d_reg;
  logic                                stall_d_reg;
  logic                                step_toggle_reg;
  logic                                lost_toggle_reg;
  logic                                wr_fire;
  logic                                rd_sample;
  logic                                pin_a_active;
  logic                                pin_b_active;
  logic [1:0]                          pin_active;
  logic [1:0]                          pin_push_pull;
  gcdr_pkg::gcdr_pad_t                 pads [2];
  logic [8:0]                          coil_a_reg;
  logic [8:0]                          coil_b_reg;
  logic signed [gcdr_pkg::PROD_W-1:0]  prod_a;
  logic signed [gcdr_pkg::PROD_W-1:0]  prod_b;
  logic signed [6:0]                   hold_scale;
  // merged words; a slice of a call result is not legal
  logic [31:0]                         cfg_merged;
  logic [31:0]                         en_merged;
  logic [31:0]                         hold_merged;

  // bus handshake: one wait cycle, read data captured in that cycle
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) &
                             (bus_state_reg == gcdr_pkg::GCDR_BUS_IDLE);
  assign wr_fire   = avs_write_i &
                     (bus_state_reg == gcdr_pkg::GCDR_BUS_ANSWER);
  assign rd_sample = avs_read_i &
                     (bus_state_reg == gcdr_pkg::GCDR_BUS_IDLE);

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      bus_state_reg <= gcdr_pkg::GCDR_BUS_IDLE;
    end else begin
      case (bus_state_reg)
        gcdr_pkg::GCDR_BUS_IDLE: begin
          if (avs_read_i | avs_write_i) begin
            bus_state_reg <= gcdr_pkg::GCDR_BUS_ANSWER;
          end
        end
        default: begin
          bus_state_reg <= gcdr_pkg::GCDR_BUS_IDLE;
        end
      endcase
    end
  end

  // pins from outside pass two flops first
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      meta_reg <= 2'h0;
      sync_reg <= 2'h0;
    end else begin
      meta_reg <= {emergency_halt_input_i, step_source_select_i};
      sync_reg <= meta_reg;
    end
  end

  assign ext_steps   = sync_reg[0];
  assign halt_active = cfg_reg.stop_enable & sync_reg[1];

  // configuration word
  assign cfg_word = {15'h0000, cfg_reg, 7'h00};

  assign cfg_merged  = be_merge(cfg_word, avs_writedata_i, avs_byteenable_i);
  assign en_merged   = be_merge({29'h0, int_enable_reg}, avs_writedata_i,
                                avs_byteenable_i);
  assign hold_merged = be_merge({27'h0, hold_current_reg}, avs_writedata_i,
                                avs_byteenable_i);

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      cfg_reg <= gcdr_pkg::CFG_RESET;
    end else if (wr_fire && avs_address_i == gcdr_pkg::OFF_CONFIG) begin
      cfg_reg <= cfg_merged[gcdr_pkg::CFG_MSB:gcdr_pkg::CFG_LSB];
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      int_enable_reg <= gcdr_pkg::INT_RESET;
    end else if (wr_fire &&
                 avs_address_i == gcdr_pkg::OFF_INT_ENABLE) begin
      int_enable_reg <= en_merged[gcdr_pkg::INT_W-1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      target_reg <= gcdr_pkg::TARGET_RESET;
    end else if (wr_fire && avs_address_i == gcdr_pkg::OFF_TARGET) begin
      target_reg <= be_merge(target_reg, avs_writedata_i, avs_byteenable_i);
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      hold_current_reg <= gcdr_pkg::HOLD_RESET;
    end else if (wr_fire && avs_address_i == gcdr_pkg::OFF_HOLD) begin
      hold_current_reg <= hold_merged[gcdr_pkg::HOLD_W-1:0];
    end
  end

  // sticky events; a set in the clearing cycle survives
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      stall_d_reg <= 1'b0;
      halt_d_reg  <= 1'b0;
    end else begin
      stall_d_reg <= stall_i;
      halt_d_reg  <= halt_active;
    end
  end

  assign int_events[gcdr_pkg::INT_STALL] = stall_i & ~stall_d_reg;
  assign int_events[gcdr_pkg::INT_LOST]  = lost_step_inc_i;
  assign int_events[gcdr_pkg::INT_HALT]  = halt_active & ~halt_d_reg;

  assign int_clear = (wr_fire && avs_address_i == gcdr_pkg::OFF_INT_CLEAR &&
                      avs_byteenable_i[0]) ?
                     avs_writedata_i[gcdr_pkg::INT_W-1:0] : 3'h0;

  always_comb begin
    int_status_next = (int_status_reg & ~int_clear) | int_events;
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      int_status_reg <= gcdr_pkg::INT_RESET;
    end else begin
      int_status_reg <= int_status_next;
    end
  end

  assign irq_o = |(int_status_reg & int_enable_reg);

  // read path, unmapped reads return zero
  always_comb begin
    if (avs_address_i == gcdr_pkg::OFF_CONFIG) begin
      read_mux = cfg_word;
    end else if (avs_address_i == gcdr_pkg::OFF_STATUS) begin
      read_mux = {27'h0, irq_o, halt_active, ext_steps,
                  pin_b_active, pin_a_active};
    end else if (avs_address_i == gcdr_pkg::OFF_INT_STATUS) begin
      read_mux = {29'h0, int_status_reg};
    end else if (avs_address_i == gcdr_pkg::OFF_INT_ENABLE) begin
      read_mux = {29'h0, int_enable_reg};
    end else if (avs_address_i == gcdr_pkg::OFF_TARGET) begin
      read_mux = target_reg;
    end else if (avs_address_i == gcdr_pkg::OFF_HOLD) begin
      read_mux = {27'h0, hold_current_reg};
    end else begin
      read_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      readdata_reg <= 32'h0000_0000;
    end else if (rd_sample) begin
      readdata_reg <= read_mux;
    end
  end

  assign avs_readdata_o = readdata_reg;

  // toggles: half-rate step, each edge one step
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      step_toggle_reg <= 1'b0;
      lost_toggle_reg <= 1'b0;
    end else begin
      if (seq_step_i) begin
        step_toggle_reg <= ~step_toggle_reg;
      end
      if (lost_step_inc_i) begin
        lost_toggle_reg <= ~lost_toggle_reg;
      end
    end
  end

  // diagnostic pin function selection
  always_comb begin
    if (ext_steps) begin
      pin_a_active = cfg_reg.pin_a_opt7 & stall_i;
      // options are ored; mixing the toggle with others is meaningless
      pin_b_active = (cfg_reg.pin_b_opt8 & stall_i) |
                     (cfg_reg.pin_b_on_table_zero &
                      (mstep_pos_i == 10'h000)) |
                     (cfg_reg.pin_b_on_chopper_on & chopper_on_i) |
                     (cfg_reg.pin_b_toggle_on_lost_step &
                      lost_toggle_reg);
    end else begin
      pin_a_active = cfg_reg.pin_a_opt7 ? step_toggle_reg :
                     (core_irq_i | irq_o);
      pin_b_active = cfg_reg.pin_b_opt8 ? seq_dir_i :
                     pos_compare_i;
    end
  end

  assign pin_active    = {pin_b_active, pin_a_active};
  assign pin_push_pull = {cfg_reg.pin_b_drive_style,
                          cfg_reg.pin_a_drive_style};

  generate
    for (genvar g = 0; g < 2; g++) begin : g_pin
      gcdr_pin_drv #(
        .RESET_DRIVE_LOW (g == 0)
      ) u_drv (
        .clock_i     (clock_i),
        .reset_i     (reset_i),
        .active_i    (pin_active[g]),
        .push_pull_i (pin_push_pull[g]),
        .pad_o       (pads[g])
      );
    end
  endgenerate

  assign diagnostic_pin_a_pad_o = pads[0];
  assign diagnostic_pin_b_pad_o = pads[1];

  assign sequencer_halt_o     = halt_active;
  assign hysteresis_divisor_o = cfg_reg.small_hyst ?
                                gcdr_pkg::HYST_DIV_SMALL :
                                gcdr_pkg::HYST_DIV_LARGE;

  // direct coil mode, scaled by (hold+1)/32 so full hold passes unchanged
  // seven bits: a scale of 32 would wrap negative in six
  assign hold_scale = $signed({2'b00, hold_current_reg}) + 7'sh01;
  assign prod_a = $signed(target_reg[gcdr_pkg::COIL_A_LSB +:
                                     gcdr_pkg::COIL_W]) * hold_scale;
  assign prod_b = $signed(target_reg[gcdr_pkg::COIL_B_LSB +:
                                     gcdr_pkg::COIL_W]) * hold_scale;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      coil_a_reg <= 9'h000;
      coil_b_reg <= 9'h000;
    end else if (cfg_reg.direct_mode) begin
      coil_a_reg <= prod_a[gcdr_pkg::HOLD_SHIFT +:
                           gcdr_pkg::COIL_W];
      coil_b_reg <= prod_b[gcdr_pkg::HOLD_SHIFT +:
                           gcdr_pkg::COIL_W];
    end else begin
      coil_a_reg <= 9'h000;
      coil_b_reg <= 9'h000;
    end
  end

  assign direct_mode_o             = cfg_reg.direct_mode;
  assign coil_a_current_o          = coil_a_reg;
  assign coil_b_current_o          = coil_b_reg;
  assign velocity_current_reg_en_o = ~cfg_reg.direct_mode;
  assign auto_current_reg_en_o     = ~cfg_reg.direct_mode |
                                     low_velocity_i;

endmodule

`default_nettype wire

// File: gcdr_pad_model.sv
`timescale 1ns/10ps
`default_nettype none

module gcdr_pad_model (
  input  wire gcdr_pkg::gcdr_pad_t pad_i,
  output logic                     line_o
);
  // board pull-up: a released line reads high, never the last value
  assign line_o = pad_i.oe ? pad_i.out : 1'b1;
endmodule

`default_nettype wire

// File: gcdr_properties.sv
`timescale 1ns/10ps
`default_nettype none

module gcdr_properties (
  input wire logic                clock_i,
  input wire logic                reset_i,
  input wire logic [4:0]          avs_address_i,
  input wire logic                avs_write_i,
  input wire logic [31:0]         avs_writedata_i,
  input wire logic [3:0]          avs_byteenable_i,
  input wire logic                avs_waitrequest_o,
  input wire logic                emergency_halt_input_i,
  input wire logic                low_velocity_i,
  input wire gcdr_pkg::gcdr_pad_t diagnostic_pin_a_pad_o,
  input wire gcdr_pkg::gcdr_pad_t diagnostic_pin_b_pad_o,
  input wire logic                sequencer_halt_o,
  input wire logic [5:0]          hysteresis_divisor_o,
  input wire logic                direct_mode_o,
  input wire logic [8:0]          coil_a_current_o,
  input wire logic [8:0]          coil_b_current_o,
  input wire logic                velocity_current_reg_en_o,
  input wire logic                auto_current_reg_en_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);

  logic acc;
  assign acc = avs_write_i && !avs_waitrequest_o
               && avs_address_i == gcdr_pkg::OFF_CONFIG;

  property p_reset_pin_a;
    $fell(reset_i) |-> diagnostic_pin_a_pad_o.oe
                       && !diagnostic_pin_a_pad_o.out;
  endproperty
  a_reset_pin_a: assert property (p_reset_pin_a)
    else $error("pin a not driven low by reset");
  property p_hyst;
    acc && avs_byteenable_i[1] |=> hysteresis_divisor_o ==
      ($past(avs_writedata_i[14]) ? gcdr_pkg::HYST_DIV_SMALL
                                  : gcdr_pkg::HYST_DIV_LARGE);
  endproperty
  a_hyst: assert property (p_hyst)
    else $error("hysteresis divisor wrong");
  property p_direct;
    acc && avs_byteenable_i[2] |=> direct_mode_o ==
                                   $past(avs_writedata_i[16]);
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct mode not following config");
  property p_vel;
    velocity_current_reg_en_o == !direct_mode_o;
  endproperty
  a_vel: assert property (p_vel)
    else $error("velocity regulation enable wrong");
  property p_auto;
    auto_current_reg_en_o == (!direct_mode_o || low_velocity_i);
  endproperty
  a_auto: assert property (p_auto)
    else $error("auto regulation enable wrong");
  property p_coil_zero;
    !direct_mode_o |=> coil_a_current_o == 9'h000
                       && coil_b_current_o == 9'h000;
  endproperty
  a_coil_zero: assert property (p_coil_zero)
    else $error("coil current outside direct mode");
  property p_halt;
    !$past(emergency_halt_input_i, 2) |-> !sequencer_halt_o;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt without halt input");
  property p_pin_a_pp;
    acc && avs_byteenable_i[1] && avs_writedata_i[12]
      |-> ##2 diagnostic_pin_a_pad_o.oe;
  endproperty
  a_pin_a_pp: assert property (p_pin_a_pp)
    else $error("pin a not push-pull");
  property p_pin_b_pp;
    acc && avs_byteenable_i[1] && avs_writedata_i[13]
      |-> ##2 diagnostic_pin_b_pad_o.oe;
  endproperty
  a_pin_b_pp: assert property (p_pin_b_pp)
    else $error("pin b not push-pull");

  c_direct: cover property (acc && avs_writedata_i[16]);
  c_halt: cover property (sequencer_halt_o);
  c_pin_b: cover property (diagnostic_pin_b_pad_o.out);
endmodule

bind gcdr_top gcdr_properties i_props (
  .clock_i(clock_i), .reset_i(reset_i),
  .avs_address_i(avs_address_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i),
  .avs_waitrequest_o(avs_waitrequest_o),
  .emergency_halt_input_i(emergency_halt_input_i),
  .low_velocity_i(low_velocity_i),
  .diagnostic_pin_a_pad_o(diagnostic_pin_a_pad_o),
  .diagnostic_pin_b_pad_o(diagnostic_pin_b_pad_o),
  .sequencer_halt_o(sequencer_halt_o),
  .hysteresis_divisor_o(hysteresis_divisor_o),
  .direct_mode_o(direct_mode_o),
  .coil_a_current_o(coil_a_current_o),
  .coil_b_current_o(coil_b_current_o),
  .velocity_current_reg_en_o(velocity_current_reg_en_o),
  .auto_current_reg_en_o(auto_current_reg_en_o));

`default_nettype wire

// File: gcdr_top_tb.sv
`timescale 1ns/10ps
`default_nettype none

module gcdr_top_tb;
  logic                clock_i, reset_i, rd, wr, wt, irq;
  logic [4:0]          adr;
  logic [31:0]         wd, rdat, r;
  logic                src, hin, stall, cirq, step, dir, pcmp, chop;
  logic                lost, lowv, shalt, dmode, ven, aen, wa, wb;
  logic [9:0]          mpos;
  logic [5:0]          hdiv;
  logic [8:0]          ca, cb;
  gcdr_pkg::gcdr_pad_t pa, pb;
  int                  n_errors, n_checks, i;

  gcdr_top i_dut (.clock_i(clock_i), .reset_i(reset_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .irq_o(irq),
    .step_source_select_i(src), .emergency_halt_input_i(hin),
    .diagnostic_pin_a_pad_o(pa), .diagnostic_pin_b_pad_o(pb),
    .stall_i(stall), .core_irq_i(cirq), .seq_step_i(step),
    .seq_dir_i(dir), .pos_compare_i(pcmp), .mstep_pos_i(mpos),
    .chopper_on_i(chop), .lost_step_inc_i(lost),
    .low_velocity_i(lowv), .sequencer_halt_o(shalt),
    .hysteresis_divisor_o(hdiv), .direct_mode_o(dmode),
    .coil_a_current_o(ca), .coil_b_current_o(cb),
    .velocity_current_reg_en_o(ven), .auto_current_reg_en_o(aen));
  gcdr_pad_model i_pad_a (.pad_i(pa), .line_o(wa));
  gcdr_pad_model i_pad_b (.pad_i(pb), .line_o(wb));

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    // waitrequest and read data are seen as they stand at the edge
    do begin
      @(posedge clock_i);
      n++;
      if (n > 20) begin
        chk("waitrequest", wt, 0);
        end_sim();
      end
    end while (wt !== 1'b0);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    #1;
  endtask
  task automatic wreg(logic [4:0] a, logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(string nm, logic [4:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, r, e);
  endtask
  // generous wait: two sync flops plus the pad register
  task automatic settle();
    repeat (4) @(posedge clock_i);
    #1;
  endtask

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  initial begin
    {reset_i, rd, wr, adr, wd, src, hin, stall, cirq} = '0;
    {step, dir, pcmp, chop, lost, lowv} = '0;
    reset_i = 1'b1;
    mpos = 10'h001;
    repeat (3) @(posedge clock_i);
    reset_i <= 1'b0;
    #1;
    chk("rst_pin_a", {pa.out, pa.oe}, 2'h1);
    rchk("config", 5'h00, 32'h0);
    rchk("unmapped", 5'h1c, 32'h0);
    wreg(5'h00, 32'hffff_f7ff);
    rchk("config", 5'h00, 32'h0001_f780);
    chk("hyst", hdiv, 6'h20);
    chk("vel_reg", ven, 1'b0);
    chk("auto_reg", aen, 1'b0);
    wreg(5'h00, 32'h0);
    chk("hyst", hdiv, 6'h10);
    $display("test config done");
    @(posedge clock_i);
    src <= 1'b1;
    wreg(5'h00, 32'h0000_3180);
    @(posedge clock_i);
    stall <= 1'b1;
    settle();
    chk("pin_a", wa, 1'b1);
    chk("pin_b", wb, 1'b1);
    wreg(5'h00, 32'h0000_0180);
    settle();
    chk("pin_a", wa, 1'b0);
    chk("pin_b", wb, 1'b0);
    @(posedge clock_i);
    stall <= 1'b0;
    settle();
    chk("pin_a", wa, 1'b1);
    for (i = 0; i < 2; i++) begin
      wreg(5'h00, i ? 32'h2400 : 32'h2200);
      @(posedge clock_i);
      chop <= (i == 0);
      mpos <= (i == 1) ? 10'h000 : 10'h001;
      settle();
      chk("pin_b_off", wb, 1'b0);
      @(posedge clock_i);
      mpos <= 10'h000;
      chop <= 1'b1;
      settle();
      chk("pin_b_on", wb, 1'b1);
      @(posedge clock_i);
      mpos <= 10'h001;
      chop <= 1'b0;
    end
    wreg(5'h00, 32'h2800);
    for (i = 0; i < 2; i++) begin
      @(posedge clock_i);
      lost <= 1'b1;
      @(posedge clock_i);
      lost <= 1'b0;
      settle();
      chk("pin_b_lost", wb, i == 0);
    end
    $display("test external done");
    @(posedge clock_i);
    src <= 1'b0;
    mpos <= 10'h000;
    wreg(5'h00, 32'h2200);
    settle();
    chk("pin_b_int", wb, 1'b0);
    @(posedge clock_i);
    pcmp <= 1'b1;
    settle();
    chk("pin_b_cmp", wb, 1'b1);
    wreg(5'h00, 32'h3180);
    settle();
    chk("pin_a_step", wa, 1'b0);
    chk("pin_b_dir", wb, 1'b0);
    @(posedge clock_i);
    step <= 1'b1;
    dir <= 1'b1;
    @(posedge clock_i);
    step <= 1'b0;
    settle();
    chk("pin_a_step", wa, 1'b1);
    chk("pin_b_dir", wb, 1'b1);
    wreg(5'h00, 32'h3100);
    @(posedge clock_i);
    cirq <= 1'b1;
    settle();
    chk("pin_a_irq", wa, 1'b1);
    $display("test internal done");
    wreg(5'h00, 32'h8000);
    @(posedge clock_i);
    hin <= 1'b1;
    settle();
    chk("halt", shalt, 1'b1);
    wreg(5'h00, 32'h0);
    chk("halt", shalt, 1'b0);
    wreg(5'h18, 32'h1f);
    wreg(5'h14, 32'h01f0_00ff);
    wreg(5'h00, 32'h1_0000);
    settle();
    chk("coil_a", ca, 9'h0ff);
    chk("coil_b", cb, 9'h1f0);
    wreg(5'h18, 32'h0f);
    settle();
    chk("coil_a", ca, 9'h07f);
    chk("coil_b", cb, 9'h1f8);
    chk("direct", dmode, 1'b1);
    chk("auto_reg", aen, 1'b0);
    @(posedge clock_i);
    lowv <= 1'b1;
    @(posedge clock_i);
    #1;
    chk("auto_reg", aen, 1'b1);
    $display("test direct done");
    rchk("int_status", 5'h08, 32'h7);
    chk("irq_masked", irq, 1'b0);
    wreg(5'h10, 32'h1);
    chk("irq", irq, 1'b1);
    wreg(5'h0c, 32'h1);
    chk("irq", irq, 1'b0);
    rchk("int_status", 5'h08, 32'h6);
    rchk("int_clear", 5'h0c, 32'h0);
    rchk("status", 5'h04, 32'h3);
    $display("test interrupt done");
    end_sim();
  end
endmodule

`default_nettype wire
